// ==== src/ivam_pkg.sv ====
/*
 * Constants, slot numbers and state codes for the interrupt vector
 * address map. Assumes a word-addressed program memory of up to 8K
 * words and a core that fetches the vector address this block offers.
 */
// Notes on behaviour
// - A vector slot is one word on the small and mid variants, two on the large.
// - The small variant has no boot area, so reset vector and table base never move.
// - With a boot area, the boot-reset fuse picks where the reset vector sits.
// - With a boot area, the vector-select bit picks where the interrupt table starts.
// - With a boot area and vector-select set, each vector is its base address plus the boot area start.
// - Every reset cause goes to the one reset vector at slot zero.
// - The two external requests sit at slots one and two, ahead of all others.
// - The three pin-change groups sit at slots three to five.
// - Watchdog sits at slot six, then the async timer compare A, B, overflow at seven to nine.
// - The wide timer capture, compare A, compare B, overflow sit at slots ten to thirteen.
// - The first timer compare A, compare B, overflow sit at slots fourteen to sixteen.
// - SPI done sits at seventeen, then USART receive, data empty, transmit at eighteen to twenty.
// - ADC, EEPROM ready, comparator, two-wire, store-program ready sit at twenty-one to twenty-five.
package ivam_pkg;

	localparam int ADDR_W  = 13;	// Word address, 8K words max
	localparam int SLOT_W  = 5;
	localparam int N_SLOTS = 26;	// Reset plus 25 interrupt sources

	// Device variant codes
	localparam logic [1:0] VARIANT_SMALL = 2'h0;
	localparam logic [1:0] VARIANT_MID   = 2'h1;
	localparam logic [1:0] VARIANT_LARGE = 2'h2;

	// Slot size as a left shift of the slot index
	localparam int SLOT_SHIFT_NARROW = 0;
	localparam int SLOT_SHIFT_WIDE   = 1;

	// Fuse level meaning programmed (boot reset wanted)
	localparam logic FUSE_PROGRAMMED = 1'h0;

	localparam logic [ADDR_W-1:0] APP_BASE = 13'h0000;

	// Slot numbers of each source
	localparam int SLOT_RESET       = 0;
	localparam int SLOT_EXT0        = 1;
	localparam int SLOT_EXT1        = 2;
	localparam int SLOT_PCG0        = 3;
	localparam int SLOT_PCG1        = 4;
	localparam int SLOT_PCG2        = 5;
	localparam int SLOT_WDOG        = 6;
	localparam int SLOT_ATIM_CMPA   = 7;
	localparam int SLOT_ATIM_CMPB   = 8;
	localparam int SLOT_ATIM_OVF    = 9;
	localparam int SLOT_WTIM_CAPT   = 10;
	localparam int SLOT_WTIM_CMPA   = 11;
	localparam int SLOT_WTIM_CMPB   = 12;
	localparam int SLOT_WTIM_OVF    = 13;
	localparam int SLOT_FTIM_CMPA   = 14;
	localparam int SLOT_FTIM_CMPB   = 15;
	localparam int SLOT_FTIM_OVF    = 16;
	localparam int SLOT_SPI_DONE    = 17;
	localparam int SLOT_USART_RX    = 18;
	localparam int SLOT_USART_EMPTY = 19;
	localparam int SLOT_USART_TX    = 20;
	localparam int SLOT_ADC         = 21;
	localparam int SLOT_EEPROM      = 22;
	localparam int SLOT_ACOMP       = 23;
	localparam int SLOT_TWO_WIRE    = 24;
	localparam int SLOT_STORE_PROG  = 25;

	typedef enum logic [1:0] {
		ST_STRAP = 2'h1,
		ST_RUN   = 2'h2
	} ivam_state_type;

endpackage

// ==== src/ivam_prio_enc.sv ====
/*
 * Fixed-priority encoder: lowest set request index wins.
 * Assumes request bit 0 is the reset slot and is driven low.
 */
`timescale 1ns/1ns
`default_nettype none

module ivam_prio_enc
(
	input  wire logic [ivam_pkg::N_SLOTS-1:0] i_req,
	output logic                              o_any,
	output logic      [ivam_pkg::SLOT_W-1:0]  o_index
);

	logic [ivam_pkg::N_SLOTS-1:0] seen;
	logic [ivam_pkg::N_SLOTS-1:0] grant;
	logic [ivam_pkg::SLOT_W-1:0]  idx_acc [ivam_pkg::N_SLOTS];

	assign seen[0]    = 1'h0;
	assign grant[0]   = i_req[0];
	assign idx_acc[0] = '0;

	// Ripple from low index; a lower request masks all above it
	genvar g;
	generate
		for (g = 1; g < ivam_pkg::N_SLOTS; g++)
		begin : g_bit
			assign seen[g]    = seen[g-1] | i_req[g-1];
			assign grant[g]   = i_req[g] & ~seen[g];
			assign idx_acc[g] = idx_acc[g-1] |
				(grant[g] ? ivam_pkg::SLOT_W'(g) : '0);
		end
	endgenerate

	assign o_any   = |i_req;
	assign o_index = idx_acc[ivam_pkg::N_SLOTS-1];

endmodule

`default_nettype wire

// ==== src/ivam_vector_map.sv ====
/*
 * Reset and interrupt vector address map for the core.
 * Assumes strap inputs (variant, boot-reset fuse) are stable from reset,
 * the vector-select bit comes from the core control register, the boot
 * start word address is supplied by the boot-size logic, and all request
 * levels are synchronous to i_core_clk.
 * Variant code 3 is taken as boot-capable with one-word slots.
 */
`timescale 1ns/1ns
`default_nettype none

module ivam_vector_map
(
	input  wire logic                           i_core_clk,
	input  wire logic                           i_arst_n,
	// Straps and control
	input  wire logic [1:0]                     i_variant,
	input  wire logic                           i_boot_reset_select_fuse,
	input  wire logic                           i_vector_base_select_bit,
	input  wire logic [ivam_pkg::ADDR_W-1:0]    i_boot_start_addr,
	// Pending request levels, one per source
	input  wire logic                           i_external_request_zero,
	input  wire logic                           i_external_request_one,
	input  wire logic                           i_pin_change_group_zero,
	input  wire logic                           i_pin_change_group_one,
	input  wire logic                           i_pin_change_group_two,
	input  wire logic                           i_watchdog_timeout_source,
	input  wire logic                           i_async_timer_compare_a,
	input  wire logic                           i_async_timer_compare_b,
	input  wire logic                           i_async_timer_overflow,
	input  wire logic                           i_wide_timer_capture,
	input  wire logic                           i_wide_timer_compare_a,
	input  wire logic                           i_wide_timer_compare_b,
	input  wire logic                           i_wide_timer_overflow,
	input  wire logic                           i_first_timer_compare_a,
	input  wire logic                           i_first_timer_compare_b,
	input  wire logic                           i_first_timer_overflow,
	input  wire logic                           i_spi_transfer_done,
	input  wire logic                           i_usart_rx_done,
	input  wire logic                           i_usart_data_empty,
	input  wire logic                           i_usart_tx_done,
	input  wire logic                           i_adc_done,
	input  wire logic                           i_eeprom_ready_source,
	input  wire logic                           i_analog_compare,
	input  wire logic                           i_two_wire_serial_source,
	input  wire logic                           i_store_program_ready_source,
	// Vector outputs to the core
	output logic      [ivam_pkg::ADDR_W-1:0]    o_reset_vector,
	output logic      [ivam_pkg::ADDR_W-1:0]    o_table_base,
	output logic                                o_irq_valid,
	output logic      [ivam_pkg::SLOT_W-1:0]    o_irq_slot,
	output logic      [ivam_pkg::ADDR_W-1:0]    o_irq_vector
);

	logic                            rst_meta_r;
	logic                            rst_n_r;
	ivam_pkg::ivam_state_type        state_r;
	ivam_pkg::ivam_state_type        state_nxt;
	logic [1:0]                      variant_r;
	logic                            fuse_r;
	logic [ivam_pkg::N_SLOTS-1:0]    pend;
	logic                            pend_any;
	logic [ivam_pkg::SLOT_W-1:0]     pend_slot;
	logic                            has_boot;
	logic                            wide_slot;
	logic                            boot_reset;
	logic                            boot_table;
	logic [ivam_pkg::ADDR_W-1:0]     tab_base;
	logic [ivam_pkg::ADDR_W-1:0]     rst_addr;
	logic [ivam_pkg::ADDR_W-1:0]     slot_off;
	logic [ivam_pkg::ADDR_W-1:0]     vec_addr;
	logic                            running;
	logic                            slot_shift;
	logic                            irq_offer;

	// Reset release through two flops; asserts at once, releases late
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_meta_r <= 1'h0;
			rst_n_r    <= 1'h0;
		end
		else
		begin
			rst_meta_r <= 1'h1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// Straps are caught once, in the first cycle after release
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ivam_pkg::ST_STRAP: state_nxt = ivam_pkg::ST_RUN;
			ivam_pkg::ST_RUN:   state_nxt = ivam_pkg::ST_RUN;
		endcase
	end

	// State register; back to strap phase on every reset
	always_ff @(posedge i_core_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			state_r <= ivam_pkg::ST_STRAP;
		else
			state_r <= state_nxt;
	end

	// Strap capture; fuse defaults to unprogrammed until sampled
	always_ff @(posedge i_core_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			variant_r <= ivam_pkg::VARIANT_SMALL;
			fuse_r    <= ~ivam_pkg::FUSE_PROGRAMMED;
		end
		else if (state_r == ivam_pkg::ST_STRAP)
		begin
			variant_r <= i_variant;
			fuse_r    <= i_boot_reset_select_fuse;
		end
	end

	assign running = (state_r == ivam_pkg::ST_RUN);

	// Requests gathered by slot; slot 0 is reset and never pends
	assign pend[ivam_pkg::SLOT_RESET]       = 1'h0;
	assign pend[ivam_pkg::SLOT_EXT0]        = i_external_request_zero;
	assign pend[ivam_pkg::SLOT_EXT1]        = i_external_request_one;
	assign pend[ivam_pkg::SLOT_PCG0]        = i_pin_change_group_zero;
	assign pend[ivam_pkg::SLOT_PCG1]        = i_pin_change_group_one;
	assign pend[ivam_pkg::SLOT_PCG2]        = i_pin_change_group_two;
	assign pend[ivam_pkg::SLOT_WDOG]        = i_watchdog_timeout_source;
	assign pend[ivam_pkg::SLOT_ATIM_CMPA]   = i_async_timer_compare_a;
	assign pend[ivam_pkg::SLOT_ATIM_CMPB]   = i_async_timer_compare_b;
	assign pend[ivam_pkg::SLOT_ATIM_OVF]    = i_async_timer_overflow;
	assign pend[ivam_pkg::SLOT_WTIM_CAPT]   = i_wide_timer_capture;
	assign pend[ivam_pkg::SLOT_WTIM_CMPA]   = i_wide_timer_compare_a;
	assign pend[ivam_pkg::SLOT_WTIM_CMPB]   = i_wide_timer_compare_b;
	assign pend[ivam_pkg::SLOT_WTIM_OVF]    = i_wide_timer_overflow;
	assign pend[ivam_pkg::SLOT_FTIM_CMPA]   = i_first_timer_compare_a;
	assign pend[ivam_pkg::SLOT_FTIM_CMPB]   = i_first_timer_compare_b;
	assign pend[ivam_pkg::SLOT_FTIM_OVF]    = i_first_timer_overflow;
	assign pend[ivam_pkg::SLOT_SPI_DONE]    = i_spi_transfer_done;
	assign pend[ivam_pkg::SLOT_USART_RX]    = i_usart_rx_done;
	assign pend[ivam_pkg::SLOT_USART_EMPTY] = i_usart_data_empty;
	assign pend[ivam_pkg::SLOT_USART_TX]    = i_usart_tx_done;
	assign pend[ivam_pkg::SLOT_ADC]         = i_adc_done;
	assign pend[ivam_pkg::SLOT_EEPROM]      = i_eeprom_ready_source;
	assign pend[ivam_pkg::SLOT_ACOMP]       = i_analog_compare;
	assign pend[ivam_pkg::SLOT_TWO_WIRE]    = i_two_wire_serial_source;
	assign pend[ivam_pkg::SLOT_STORE_PROG]  = i_store_program_ready_source;

	// Lowest slot wins, so the lowest address is served first
	ivam_prio_enc u_prio
	(
		.i_req   (pend),
		.o_any   (pend_any),
		.o_index (pend_slot)
	);

	// Variant decode
	assign has_boot  = (variant_r != ivam_pkg::VARIANT_SMALL);
	assign wide_slot = (variant_r == ivam_pkg::VARIANT_LARGE);

	// Relocation only where a boot area exists
	assign boot_reset = has_boot &&
		(fuse_r == ivam_pkg::FUSE_PROGRAMMED);
	assign boot_table = has_boot && i_vector_base_select_bit;

	assign rst_addr = boot_reset ? i_boot_start_addr
		: ivam_pkg::APP_BASE;
	assign tab_base = boot_table ? i_boot_start_addr
		: ivam_pkg::APP_BASE;

	// Slot size as a shift; top bits of the offset stay zero
	assign slot_shift = wide_slot ? 1'(ivam_pkg::SLOT_SHIFT_WIDE)
		: 1'(ivam_pkg::SLOT_SHIFT_NARROW);
	assign slot_off = ivam_pkg::ADDR_W'(pend_slot)
		<< slot_shift;

	// Wraps inside program memory if the boot start is near the top
	assign vec_addr = tab_base + slot_off;

	// Nothing is offered before straps are known
	assign irq_offer = running && pend_any;

	// Reset and table addresses, held in flops for the core
	always_ff @(posedge i_core_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			o_reset_vector <= ivam_pkg::APP_BASE;
			o_table_base   <= ivam_pkg::APP_BASE;
		end
		else
		begin
			o_reset_vector <= rst_addr;
			o_table_base   <= tab_base;
		end
	end

	// Request outputs; one cycle behind the request levels
	always_ff @(posedge i_core_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			o_irq_valid    <= 1'h0;
			o_irq_slot     <= '0;
			o_irq_vector   <= ivam_pkg::APP_BASE;
		end
		else
		begin
			o_irq_valid    <= irq_offer;
			o_irq_slot     <= pend_slot;
			o_irq_vector   <= vec_addr;
		end
	end

endmodule

`default_nettype wire

// ==== tb/ivam_core_model.sv ====
/* Core side: fetches whatever vector is offered while a request is pending.
   Assumes the map's outputs are registered on the same clock. */
`timescale 1ns/1ns
`default_nettype none
module ivam_core_model
(
	input  wire logic        i_core_clk,
	input  wire logic        i_irq_valid,
	input  wire logic [12:0] i_irq_vector,
	output logic      [12:0] o_fetch_addr
);
	// No dispatch logic here; the map already picked the winner
	always_ff @(posedge i_core_clk)
		if (i_irq_valid)
			o_fetch_addr <= i_irq_vector;
endmodule
`default_nettype wire

// ==== tb/ivam_monitor.sv ====
/* Checker for the vector map outputs against the strap and request inputs.
   Assumes straps change only while reset is held low. */
`timescale 1ns/1ns
`default_nettype none
module ivam_monitor
(
	input wire logic        i_core_clk,
	input wire logic        i_arst_n,
	input wire logic [1:0]  i_variant,
	input wire logic        i_boot_reset_select_fuse,
	input wire logic        i_vector_base_select_bit,
	input wire logic [12:0] i_boot_start_addr,
	input wire logic        i_external_request_zero,
	input wire logic        i_external_request_one,
	input wire logic        i_pin_change_group_zero,
	input wire logic        i_pin_change_group_one,
	input wire logic        i_pin_change_group_two,
	input wire logic        i_watchdog_timeout_source,
	input wire logic        i_async_timer_compare_a,
	input wire logic        i_async_timer_compare_b,
	input wire logic        i_async_timer_overflow,
	input wire logic        i_wide_timer_capture,
	input wire logic        i_wide_timer_compare_a,
	input wire logic        i_wide_timer_compare_b,
	input wire logic        i_wide_timer_overflow,
	input wire logic        i_first_timer_compare_a,
	input wire logic        i_first_timer_compare_b,
	input wire logic        i_first_timer_overflow,
	input wire logic        i_spi_transfer_done,
	input wire logic        i_usart_rx_done,
	input wire logic        i_usart_data_empty,
	input wire logic        i_usart_tx_done,
	input wire logic        i_adc_done,
	input wire logic        i_eeprom_ready_source,
	input wire logic        i_analog_compare,
	input wire logic        i_two_wire_serial_source,
	input wire logic        i_store_program_ready_source,
	input wire logic [12:0] o_reset_vector,
	input wire logic [12:0] o_table_base,
	input wire logic        o_irq_valid,
	input wire logic [4:0]  o_irq_slot,
	input wire logic [12:0] o_irq_vector
);
	logic [2:0]  cnt_r;
	logic [25:0] req;
	logic [4:0]  low;
	logic        ok;
	logic        boot;
	// Request levels by slot; slot zero is reset and never pending
	assign req = {i_store_program_ready_source, i_two_wire_serial_source,
		i_analog_compare, i_eeprom_ready_source, i_adc_done, i_usart_tx_done,
		i_usart_data_empty, i_usart_rx_done, i_spi_transfer_done,
		i_first_timer_overflow, i_first_timer_compare_b,
		i_first_timer_compare_a, i_wide_timer_overflow, i_wide_timer_compare_b,
		i_wide_timer_compare_a, i_wide_timer_capture, i_async_timer_overflow,
		i_async_timer_compare_b, i_async_timer_compare_a,
		i_watchdog_timeout_source, i_pin_change_group_two,
		i_pin_change_group_one, i_pin_change_group_zero,
		i_external_request_one, i_external_request_zero, 1'h0};
	assign ok = (cnt_r == 3'h7);
	assign boot = (i_variant != 2'h0);
	// Lowest pending slot wins
	always_comb
	begin
		low = 5'h00;
		for (int k = 25; k > 0; k--)
			if (req[k])
				low = 5'(k);
	end
	// Saturating edge count; keeps the strap phase out of the checks
	always_ff @(posedge i_core_clk or negedge i_arst_n)
		if (!i_arst_n)
			cnt_r <= 3'h0;
		else if (!ok)
			cnt_r <= cnt_r + 3'h1;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_ext;
		ok && i_external_request_zero;
	endsequence
	sequence s_quiet;
		ok && !(|req) ##1 !(|req);
	endsequence
	property p_valid; ok |=> (o_irq_valid == $past(|req)); endproperty
	property p_slot; ok |=> (o_irq_slot == $past(low)); endproperty
	property p_base;
		ok |=> (o_table_base == ($past(boot && i_vector_base_select_bit) ?
			$past(i_boot_start_addr) : 13'h0000));
	endproperty
	property p_reset;
		ok |=> (o_reset_vector == ($past(boot && !i_boot_reset_select_fuse) ?
			$past(i_boot_start_addr) : 13'h0000));
	endproperty
	property p_small;
		ok && !boot |-> o_reset_vector == 13'h0000 && o_table_base == 13'h0000;
	endproperty
	property p_vector;
		ok |-> (o_irq_vector ==
			o_table_base + (13'(o_irq_slot) << (i_variant == 2'h2)));
	endproperty
	property p_ext; s_ext |=> (o_irq_slot == 5'h01); endproperty
	property p_idle; s_quiet |-> !o_irq_valid && o_irq_slot == 5'h00; endproperty
	a_valid: assert property (p_valid) else $error("valid mismatch");
	a_slot: assert property (p_slot) else $error("slot mismatch");
	a_base: assert property (p_base) else $error("base mismatch");
	a_reset: assert property (p_reset) else $error("reset vec bad");
	a_small: assert property (p_small) else $error("small moved");
	a_vector: assert property (p_vector) else $error("vector bad");
	a_ext: assert property (p_ext) else $error("ext0 not first");
	a_idle: assert property (p_idle) else $error("idle not quiet");
endmodule
bind ivam_vector_map ivam_monitor u_ivam_monitor
(
	.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_variant(i_variant),
	.i_boot_reset_select_fuse(i_boot_reset_select_fuse),
	.i_vector_base_select_bit(i_vector_base_select_bit),
	.i_boot_start_addr(i_boot_start_addr),
	.i_external_request_zero(i_external_request_zero),
	.i_external_request_one(i_external_request_one),
	.i_pin_change_group_zero(i_pin_change_group_zero),
	.i_pin_change_group_one(i_pin_change_group_one),
	.i_pin_change_group_two(i_pin_change_group_two),
	.i_watchdog_timeout_source(i_watchdog_timeout_source),
	.i_async_timer_compare_a(i_async_timer_compare_a),
	.i_async_timer_compare_b(i_async_timer_compare_b),
	.i_async_timer_overflow(i_async_timer_overflow),
	.i_wide_timer_capture(i_wide_timer_capture),
	.i_wide_timer_compare_a(i_wide_timer_compare_a),
	.i_wide_timer_compare_b(i_wide_timer_compare_b),
	.i_wide_timer_overflow(i_wide_timer_overflow),
	.i_first_timer_compare_a(i_first_timer_compare_a),
	.i_first_timer_compare_b(i_first_timer_compare_b),
	.i_first_timer_overflow(i_first_timer_overflow),
	.i_spi_transfer_done(i_spi_transfer_done),
	.i_usart_rx_done(i_usart_rx_done),
	.i_usart_data_empty(i_usart_data_empty),
	.i_usart_tx_done(i_usart_tx_done), .i_adc_done(i_adc_done),
	.i_eeprom_ready_source(i_eeprom_ready_source),
	.i_analog_compare(i_analog_compare),
	.i_two_wire_serial_source(i_two_wire_serial_source),
	.i_store_program_ready_source(i_store_program_ready_source),
	.o_reset_vector(o_reset_vector), .o_table_base(o_table_base),
	.o_irq_valid(o_irq_valid), .o_irq_slot(o_irq_slot),
	.o_irq_vector(o_irq_vector)
);
`default_nettype wire

// ==== tb/testbench.sv ====
/* Self-checking bench for the vector map and a fetching core.
   Assumes outputs settle one edge after inputs change. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        clk = 1'h0;
	logic        arst_n;
	logic [1:0]  variant;
	logic        fuse;
	logic        sel;
	logic [12:0] boot;
	logic [25:1] rq;
	wire  [12:0] rst_vec, base, vec, fetch;
	wire  [4:0]  slot;
	wire         valid;
	int          err_total, n_checks, cyc;
	ivam_vector_map u_ivam_vector_map
	(
		.i_core_clk(clk), .i_arst_n(arst_n), .i_variant(variant),
		.i_boot_reset_select_fuse(fuse), .i_vector_base_select_bit(sel),
		.i_boot_start_addr(boot), .i_external_request_zero(rq[1]),
		.i_external_request_one(rq[2]), .i_pin_change_group_zero(rq[3]),
		.i_pin_change_group_one(rq[4]), .i_pin_change_group_two(rq[5]),
		.i_watchdog_timeout_source(rq[6]), .i_async_timer_compare_a(rq[7]),
		.i_async_timer_compare_b(rq[8]), .i_async_timer_overflow(rq[9]),
		.i_wide_timer_capture(rq[10]), .i_wide_timer_compare_a(rq[11]),
		.i_wide_timer_compare_b(rq[12]), .i_wide_timer_overflow(rq[13]),
		.i_first_timer_compare_a(rq[14]), .i_first_timer_compare_b(rq[15]),
		.i_first_timer_overflow(rq[16]), .i_spi_transfer_done(rq[17]),
		.i_usart_rx_done(rq[18]), .i_usart_data_empty(rq[19]),
		.i_usart_tx_done(rq[20]), .i_adc_done(rq[21]),
		.i_eeprom_ready_source(rq[22]), .i_analog_compare(rq[23]),
		.i_two_wire_serial_source(rq[24]),
		.i_store_program_ready_source(rq[25]), .o_reset_vector(rst_vec),
		.o_table_base(base), .o_irq_valid(valid), .o_irq_slot(slot),
		.o_irq_vector(vec)
	);
	ivam_core_model u_ivam_core_model
	(
		.i_core_clk(clk), .i_irq_valid(valid), .i_irq_vector(vec),
		.o_fetch_addr(fetch)
	);
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Reset with every request up; nothing may be offered meanwhile
	task automatic restart(input logic [1:0] v, input logic f,
		input logic [12:0] b);
		arst_n = 1'h0;
		variant = v;
		fuse = f;
		boot = b;
		rq = '1;
		repeat (5) @(negedge clk);
		chk(13'(valid), 13'h0000);
		arst_n = 1'h1;
		// Requests held: no offer until the straps are caught
		repeat (3)
		begin
			@(negedge clk);
			chk(13'(valid), 13'h0000);
		end
		@(negedge clk);
		chk(13'(valid), 13'h0001);
		chk(13'(slot), 13'h0001);
		rq = '0;
		repeat (2) @(negedge clk);
	endtask
	// Walk slots downward, so each step adds a lower winner
	task automatic t_map(input logic [1:0] v, input logic f, input logic s,
		input logic [12:0] b);
		logic [12:0] b0;
		logic [1:0]  sh;
		restart(v, f, b);
		sel = s;
		b0 = (v != 2'h0 && s) ? b : 13'h0000;
		sh = (v == 2'h2) ? 2'h1 : 2'h0;
		@(negedge clk);
		chk(rst_vec, (v != 2'h0 && !f) ? b : 13'h0000);
		chk(base, b0);
		for (int k = 25; k >= 1; k--)
		begin
			rq[k] = 1'h1;
			@(negedge clk);
			chk(13'(slot), 13'(k));
			chk(vec, b0 + (13'(k) << sh));
		end
		@(negedge clk);
		chk(fetch, b0 + (13'h0001 << sh));
		rq = '0;
		@(negedge clk);
		chk(13'(valid), 13'h0000);
		chk(vec, b0);
		$display("t_map variant %0d fuse %0d select %0d done", v, f, s);
	endtask
	initial
	begin
		forever #5 clk = ~clk;
	end
	// Hang guard well above the expected run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			end_sim();
		end
	end
	initial
	begin
		arst_n = 1'h0;
		variant = 2'h0;
		fuse = 1'h1;
		sel = 1'h0;
		boot = 13'h0000;
		rq = '0;
		t_map(2'h0, 1'h0, 1'h1, 13'h1e00);
		t_map(2'h1, 1'h1, 1'h0, 13'h0c00);
		t_map(2'h1, 1'h0, 1'h1, 13'h0e00);
		t_map(2'h2, 1'h0, 1'h1, 13'h1c00);
		t_map(2'h2, 1'h1, 1'h1, 13'h1f00);
		t_map(2'h3, 1'h0, 1'h0, 13'h0800);
		end_sim();
	end
endmodule
`default_nettype wire
